// *** hw/mrf_pkg.sv ***
// Package for the reset, fetch-select, latch-pulse, port four and flash map block.
// Assumes a single 25 MHz clock and an AXI4-Lite register bus.
`default_nettype none
package mrf_pkg;
  // ------------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] MRF_CTRL_OFF   = 8'h00;
  localparam logic [7:0] MRF_STATUS_OFF = 8'h04;
  localparam logic [7:0] MRF_PORT_OFF   = 8'h08;
  localparam logic [7:0] MRF_MAP_OFF    = 8'h0C;
  localparam logic [7:0] MRF_MAPRES_OFF = 8'h10;
  // Control register fields
  localparam int CTRL_INHIBIT_BIT = 0;
  localparam int CTRL_SIXCLK_BIT  = 1;
  localparam int CTRL_LOCK4_BIT   = 2;
  localparam int CTRL_CFG_LSB     = 4;
  localparam int CTRL_BIG_BIT     = 6;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [3:0]  PORT_RESET  = 4'hF;
  // Status register fields
  localparam int STAT_INRESET_BIT = 0;
  localparam int STAT_HOSTPRG_BIT = 1;
  localparam int STAT_EXTFET_BIT  = 2;
  localparam int STAT_IRQ3_BIT    = 3;
  localparam int STAT_IRQ2_BIT    = 4;
  // Timing
  localparam int XTAL_PER_MC_STD  = 12;
  localparam int XTAL_PER_MC_FAST = 6;
  localparam int RESET_MC         = 2;
  localparam int ALE_DIV_STD      = 6;
  localparam int ALE_DIV_FAST     = 3;
  // Flash layout
  localparam int SECTOR_BITS      = 7;
  localparam int PRI_SECT_SMALL   = 128;
  localparam int PRI_SECT_BIG     = 256;
  localparam int SEC_SECTORS      = 64;
  localparam logic [15:0] OVL_TOP = 16'h1FFF;
  localparam logic [15:0] PRI_TOP = 16'h7FFF;
  localparam logic [15:0] SEC_BASE = 16'hE000;
  localparam logic [1:0]  AXI_OKAY   = 2'b00;
  localparam logic [1:0]  AXI_SLVERR = 2'b10;

  typedef enum {MRF_RUN, MRF_RESET, MRF_ENTRY, MRF_HOST} mrf_mode_e;

  // Flash translation result
  typedef struct packed {
    logic       hit;       // Internal flash holds the address
    logic       secondary; // 1 = secondary block, 0 = primary
    logic [7:0] sector;
    logic [6:0] offset;
  } mrf_map_s;
endpackage
`default_nettype wire

// *** hw/mrf_core.sv ***
// Reset detection, fetch select, latch pulse, port four and flash address map.
// Pins are synchronous to aclk; crystal_in is a sampled input, edges count.
//
// Design decisions made here: the address map and register access over AXI4-Lite.
`default_nettype none
module mrf_core
  import mrf_pkg::*;
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Device pins
  input  wire logic        crystal_in,
  input  wire logic        reset_pin,
  input  wire logic        program_store_strobe_n,
  input  wire logic        external_fetch_select_n,
  input  wire logic        data_access,
  output logic             latch_pulse,
  input  wire logic [3:0]  port_four_in,
  output logic [3:0]       port_four_out,
  output logic [3:0]       port_four_oe_n,
  // Core status
  output logic             core_reset,
  output logic             host_program_mode,
  output logic             fetch_external,
  output logic             ext_irq_two_n,
  output logic             ext_irq_three_n
);

  // ------------------------------------------------------------------
  // Flash translation
  // ------------------------------------------------------------------
  // Decode used for the software lookup register
  function automatic mrf_map_s map_addr(input logic [15:0] a, input logic [1:0] cfg, input logic big);
    mrf_map_s m;
    logic [15:0] pri_top;
    m = '0;
    pri_top = big ? PRI_TOP : 16'h3FFF;
    m.offset = a[SECTOR_BITS-1:0];
    if (cfg == 2'b00 && a <= OVL_TOP) begin
      m.hit = 1'b1;
      m.secondary = 1'b1;
    end else if (cfg == 2'b01 && a >= SEC_BASE) begin
      m.hit = 1'b1;
      m.secondary = 1'b1;
    end else if (a <= pri_top) begin
      m.hit = 1'b1;
    end
    if (m.secondary) begin
      m.sector = {2'b00, a[12:SECTOR_BITS]};
    end else begin
      m.sector = big ? a[14:SECTOR_BITS] : {1'b0, a[13:SECTOR_BITS]};
    end
    if (!m.hit) begin
      m.sector = 8'h00;
    end
    return m;
  endfunction

  // ------------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------------
  logic [31:0] ctrl_q, ctrl_d;
  logic [3:0]  port_q, port_d;
  logic [15:0] map_q, map_d;
  logic        awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic        aw_got_q, aw_got_d, w_got_q, w_got_d;
  logic [7:0]  awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
  logic        arready_q, arready_d, rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  mrf_mode_e   mode_q, mode_d;
  logic [3:0]  xdiv_q, xdiv_d;
  logic [1:0]  hicnt_q, hicnt_d;
  logic        xtal_q, xtal_d, strobe_q, strobe_d;
  logic [2:0]  ale_q, ale_d;
  logic        skip_q, skip_d, latch_q, latch_d;
  logic        fetch_q, fetch_d, irq2_q, irq2_d, irq3_q, irq3_d;
  logic        rst_st_q, rst_st_d, host_q, host_d;

  wire logic xtal_rise = crystal_in && !xtal_q;
  wire logic six_mode  = ctrl_q[CTRL_SIXCLK_BIT];
  wire logic in_reset  = rst_st_q;

  // ------------------------------------------------------------------
  // Reset detection and mode entry
  // ------------------------------------------------------------------
  // Machine cycle runs on the sampled crystal; reset pin counted per cycle
  always_comb begin
    xtal_d   = crystal_in;
    strobe_d = program_store_strobe_n;
    xdiv_d   = xdiv_q;
    hicnt_d  = hicnt_q;
    mode_d   = mode_q;
    if (xtal_rise) begin
      if (xdiv_q >= 4'((six_mode ? XTAL_PER_MC_FAST : XTAL_PER_MC_STD) - 1)) begin
        xdiv_d = 4'h0;
        if (hicnt_q != 2'(RESET_MC)) begin
          hicnt_d = hicnt_q + 2'h1;
        end
      end else begin
        xdiv_d = xdiv_q + 4'h1;
      end
    end
    // A low pin restarts the count, so only consecutive cycles add up
    if (!reset_pin) hicnt_d = 2'h0;
    case (mode_q)
      MRF_RUN: begin
        if (hicnt_q == 2'(RESET_MC)) begin
          mode_d = MRF_RESET;
        end
      end
      MRF_HOST: if (!reset_pin) mode_d = MRF_RUN;  // Host ends by letting reset fall
      MRF_RESET: begin
        mode_d = MRF_ENTRY;
      end
      MRF_ENTRY: begin
        if (!reset_pin) begin
          mode_d = MRF_RUN;
        end else if (strobe_q && !program_store_strobe_n) begin
          mode_d = MRF_HOST;
        end
      end
      default: mode_d = MRF_RUN;
    endcase
    rst_st_d = (mode_d == MRF_RESET) || (mode_d == MRF_ENTRY);
    host_d   = (mode_d == MRF_HOST);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q   <= MRF_RUN;
      xdiv_q   <= 4'h0;
      hicnt_q  <= 2'h0;
      xtal_q   <= 1'b0;
      strobe_q <= 1'b1;
      rst_st_q <= 1'b0;
      host_q   <= 1'b0;
    end else begin
      mode_q   <= mode_d;
      xdiv_q   <= xdiv_d;
      hicnt_q  <= hicnt_d;
      xtal_q   <= xtal_d;
      strobe_q <= strobe_d;
      rst_st_q <= rst_st_d;
      host_q   <= host_d;
    end
  end

  // ------------------------------------------------------------------
  // Latch pulse, fetch select, port four
  // ------------------------------------------------------------------
  // Pulse once per divided period; high for one crystal edge interval
  always_comb begin
    ale_d   = ale_q;
    skip_d  = skip_q || data_access;
    latch_d = latch_q;
    if (xtal_rise) begin
      latch_d = 1'b0;
      if (ale_q >= 3'((six_mode ? ALE_DIV_FAST : ALE_DIV_STD) - 1)) begin
        ale_d = 3'h0;
        if (skip_q) begin
          skip_d = data_access;
        end else if (!ctrl_q[CTRL_INHIBIT_BIT] && !in_reset) begin
          latch_d = 1'b1;
        end
      end else begin
        ale_d = ale_q + 3'h1;
      end
    end
    if (in_reset) latch_d = 1'b0;  // A pulse cut short by reset, not left standing
    // low pin external; lock forces internal
    fetch_d = !external_fetch_select_n && !ctrl_q[CTRL_LOCK4_BIT];
    // bit 2 is irq three, bit 3 irq two
    irq3_d = port_four_in[2];
    irq2_d = port_four_in[3];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ale_q   <= 3'h0;
      skip_q  <= 1'b0;
      latch_q <= 1'b0;
      fetch_q <= 1'b0;
      irq2_q  <= 1'b1;
      irq3_q  <= 1'b1;
    end else begin
      ale_q   <= ale_d;
      skip_q  <= skip_d;
      latch_q <= latch_d;
      fetch_q <= fetch_d;
      irq2_q  <= irq2_d;
      irq3_q  <= irq3_d;
    end
  end

  // ------------------------------------------------------------------
  // AXI4-Lite slave
  // ------------------------------------------------------------------
  // Write address and data accepted in either order, one at a time
  always_comb begin
    ctrl_d    = ctrl_q;
    port_d    = port_q;
    map_d     = map_q;
    aw_got_d  = aw_got_q || (s_axi_awvalid && awready_q);
    w_got_d   = w_got_q || (s_axi_wvalid && wready_q);
    awaddr_d  = (s_axi_awvalid && awready_q) ? s_axi_awaddr : awaddr_q;
    wdata_d   = (s_axi_wvalid && wready_q) ? s_axi_wdata : wdata_q;
    awready_d = !aw_got_d && !bvalid_q;
    wready_d  = !w_got_d && !bvalid_q;
    bvalid_d  = bvalid_q && !s_axi_bready;
    bresp_d   = bresp_q;
    if (aw_got_q && w_got_q && !bvalid_q) begin
      bvalid_d  = 1'b1;
      bresp_d   = AXI_OKAY;
      aw_got_d  = 1'b0;
      w_got_d   = 1'b0;
      awready_d = 1'b0;
      wready_d  = 1'b0;
      case (awaddr_q)
        MRF_CTRL_OFF: if (s_axi_wstrb[0]) ctrl_d[7:0] = wdata_q[7:0];
        MRF_PORT_OFF: if (s_axi_wstrb[0]) port_d = wdata_q[3:0];
        MRF_MAP_OFF: begin
          if (s_axi_wstrb[0]) map_d[7:0] = wdata_q[7:0];
          if (s_axi_wstrb[1]) map_d[15:8] = wdata_q[15:8];
        end
        default: bresp_d = AXI_SLVERR;
      endcase
    end
    ctrl_d[31:8] = 24'h0;
    ctrl_d[3]    = 1'b0;
    arready_d = !rvalid_q && !(s_axi_arvalid && arready_q);
    rvalid_d  = rvalid_q && !s_axi_rready;
    rdata_d   = rdata_q;
    rresp_d   = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = AXI_OKAY;
      case (s_axi_araddr)
        MRF_CTRL_OFF:   rdata_d = ctrl_q;
        MRF_STATUS_OFF: rdata_d = {27'h0, irq2_q, irq3_q, fetch_q, mode_q == MRF_HOST, in_reset};
        MRF_PORT_OFF:   rdata_d = {24'h0, port_four_in, port_q};
        MRF_MAP_OFF:    rdata_d = {16'h0, map_q};
        // program map only; 16-bit space, field selects
        MRF_MAPRES_OFF: rdata_d = {15'h0,
                                   map_addr(map_q, ctrl_q[CTRL_CFG_LSB +: 2], ctrl_q[CTRL_BIG_BIT])};
        default: begin
          rdata_d = 32'h0;
          rresp_d = AXI_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q    <= CTRL_RESET;
      port_q    <= PORT_RESET;
      map_q     <= 16'h0;
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      awaddr_q  <= 8'h0;
      wdata_q   <= 32'h0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= AXI_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0;
      rresp_q   <= AXI_OKAY;
    end else begin
      ctrl_q    <= ctrl_d;
      port_q    <= port_d;
      map_q     <= map_d;
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      awaddr_q  <= awaddr_d;
      wdata_q   <= wdata_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      rresp_q   <= rresp_d;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Quasi-bidirectional: drive low only, a one leaves the pull-up
  assign port_four_out     = 4'h0;
  assign port_four_oe_n    = port_q;
  assign latch_pulse       = latch_q;
  assign core_reset        = in_reset;
  assign host_program_mode = host_q;
  assign fetch_external    = fetch_q;
  assign ext_irq_two_n     = irq2_q;
  assign ext_irq_three_n   = irq3_q;
  assign s_axi_awready     = awready_q;
  assign s_axi_wready      = wready_q;
  assign s_axi_bvalid      = bvalid_q;
  assign s_axi_bresp       = bresp_q;
  assign s_axi_arready     = arready_q;
  assign s_axi_rvalid      = rvalid_q;
  assign s_axi_rdata       = rdata_q;
  assign s_axi_rresp       = rresp_q;

endmodule
`default_nettype wire

// *** verif/mrf_core_sva.sv ***
// Checker for the reset, fetch, latch pulse and port four block.
// Sees only the core's ports; bound into every core instance below.
`default_nettype none
module mrf_core_chk
  import mrf_pkg::*;
(
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus answers
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic [31:0] s_axi_rdata,
  // Pins and status
  input wire logic        reset_pin,
  input wire logic        external_fetch_select_n,
  input wire logic        latch_pulse,
  input wire logic [3:0]  port_four_in,
  input wire logic [3:0]  port_four_out,
  input wire logic        core_reset,
  input wire logic        host_program_mode,
  input wire logic        fetch_external,
  input wire logic        ext_irq_two_n,
  input wire logic        ext_irq_three_n
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_rd_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while read data pending");
  a_wr_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  a_unmapped_zero: assert property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read returned data");
  a_reset_cause: assert property ($rose(core_reset) |-> $past(reset_pin, 3))
    else $error("internal reset without reset pin");
  a_reset_leave: assert property ((!reset_pin)[*4] |-> !core_reset)
    else $error("internal reset held after pin low");
  a_host_cause: assert property ($rose(host_program_mode) |-> $past(reset_pin))
    else $error("host mode entered without reset pin");
  a_fetch_internal: assert property (external_fetch_select_n[*4] |-> !fetch_external)
    else $error("external fetch with select high");
  a_pulse_quiet: assert property (core_reset[*2] |-> !latch_pulse)
    else $error("latch pulse during reset");
  a_port_pullup: assert property (port_four_out == 4'h0)
    else $error("port four drives high");
  a_irq_two_copy: assert property ((!port_four_in[3])[*3] |-> !ext_irq_two_n)
    else $error("interrupt two not following pin");
  a_irq_three_copy: assert property (port_four_in[2][*3] |-> ext_irq_three_n)
    else $error("interrupt three not following pin");

  // Main scenarios reached
  c_host: cover property ($rose(host_program_mode));
  c_pulse: cover property ($rose(latch_pulse));
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR);
endmodule
bind mrf_core mrf_core_chk chk_u (.*);
`default_nettype wire

// *** verif/mrf_far_model.sv ***
// Far side: crystal source, reset and programming host, port four pads.
// Driven through its tasks from the bench; one crystal tick per four aclk cycles.
`default_nettype none
module mrf_far_model (
  // Clock
  input  wire logic       aclk,
  // Device pins
  output logic            crystal_in,
  output logic            reset_pin,
  output logic            program_store_strobe_n,
  // Port four pads
  input  wire logic [3:0] port_four_oe_n,
  input  wire logic [3:0] ext_pull_low,
  output logic [3:0]      port_four_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ph_q = 2'h0;

  initial begin
    crystal_in = 1'b0;
    reset_pin = 1'b0;
    program_store_strobe_n = 1'b1;
  end

  // Crystal runs free, slow enough that every edge is sampled
  always @(posedge aclk) begin
    ph_q <= ph_q + 2'h1;
    crystal_in <= ph_q[1];
  end

  assign port_four_in = ~(~port_four_oe_n | ext_pull_low);

  task automatic hold_reset(input int mcs, input logic program_pulse_in_n);
    reset_pin <= 1'b1;
    repeat (24 * mcs) @(posedge aclk);
    if (program_pulse_in_n) program_store_strobe_n <= 1'b0;
    repeat (24 * mcs) @(posedge aclk);
  endtask

  task automatic release_reset();
    reset_pin <= 1'b0;
    program_store_strobe_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** verif/tb_mrf_core.sv ***
// Bench for the reset, fetch, latch pulse, port four and flash map block.
// Masters the register bus and drives fetch select, data access and pad pull-downs itself; crystal, reset and strobe come from the far-side model.
`default_nettype none
module tb_mrf_core
  import mrf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [31:0] data;
    logic [31:0] mask;
    logic [1:0]  resp;
  } mrf_row_s;
  localparam logic [7:0] CT = MRF_CTRL_OFF;
  localparam logic [7:0] MP = MRF_MAP_OFF;
  localparam logic [7:0] MR = MRF_MAPRES_OFF;
  localparam logic [31:0] M = 32'h1FFFF;
  // Reads carry expected data, writes the data sent
  localparam mrf_row_s ROWS [24] = '{
    '{1'b0, MRF_PORT_OFF, 32'hFF, 32'hFF, AXI_OKAY}, '{1'b0, CT, 32'h0, '1, AXI_OKAY},
    '{1'b0, 8'h14, 32'h0, '1, AXI_SLVERR}, '{1'b1, 8'h14, 32'h0, 32'h0, AXI_SLVERR},
    '{1'b1, MP, 32'h0085, 0, AXI_OKAY}, '{1'b0, MR, 32'h18085, M, AXI_OKAY},
    '{1'b1, MP, 32'h2080, 0, AXI_OKAY}, '{1'b0, MR, 32'h12080, M, AXI_OKAY},
    '{1'b1, MP, 32'h4000, 0, AXI_OKAY}, '{1'b0, MR, 32'h0, 32'h10000, AXI_OKAY},
    '{1'b1, CT, 32'h10, 0, AXI_OKAY}, '{1'b1, MP, 32'h0085, 0, AXI_OKAY},
    '{1'b0, MR, 32'h10085, M, AXI_OKAY}, '{1'b1, MP, 32'hE085, 0, AXI_OKAY},
    '{1'b0, MR, 32'h18085, M, AXI_OKAY}, '{1'b1, CT, 32'h20, 0, AXI_OKAY},
    '{1'b0, MR, 32'h0, 32'h10000, AXI_OKAY}, '{1'b1, CT, 32'h30, 0, AXI_OKAY},
    '{1'b1, MP, 32'h1F85, 0, AXI_OKAY}, '{1'b0, MR, 32'h11F85, M, AXI_OKAY},
    '{1'b1, CT, 32'h50, 0, AXI_OKAY}, '{1'b1, MP, 32'h7F85, 0, AXI_OKAY},
    '{1'b0, MR, 32'h17F85, M, AXI_OKAY}, '{1'b0, CT, 32'h50, 32'h7F, AXI_OKAY}};

  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lp_q;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        crystal_in, reset_pin, program_store_strobe_n, external_fetch_select_n, data_access;
  logic        latch_pulse, core_reset, host_program_mode, fetch_external, ext_irq_two_n, ext_irq_three_n;
  logic [3:0]  port_four_in, port_four_out, port_four_oe_n, ext_pull_low;
  int          num_errors, n_checks, g;

  mrf_core dut_u (.*, .s_axi_wstrb(4'hF));
  mrf_far_model far_u (.*);

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Previous pulse level, for edge detection
  always @(posedge aclk) lp_q <= latch_pulse;

  task automatic stop_test();
    if (num_errors == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One bus transfer; both halves of a write offered together
  task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic [1:0] rs);
    int n;
    n = 0;
    rd = 32'h0;
    @(posedge aclk);
    if (w) begin
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_bready <= 1'b1;
      do begin
        @(posedge aclk);
        n++;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid && n < 50);
      s_axi_bready <= 1'b0;
      rs = s_axi_bresp;
    end else begin
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do begin
        @(posedge aclk);
        n++;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid && n < 50);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
    end
    if (n >= 50) begin
      num_errors++;
      stop_test();
    end
  endtask

  // Cycles between two latch pulses; a data access may be signalled after the first
  task automatic gap(input logic skip, output int gc);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (!(latch_pulse && !lp_q) && n < 400);
    data_access <= skip;
    gc = 0;
    do begin
      @(posedge aclk);
      data_access <= 1'b0;
      gc++;
    end while (!(latch_pulse && !lp_q) && gc < 400);
  endtask

  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, data_access, ext_pull_low} = '0;
    external_fetch_select_n = 1'b1;
    num_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (ROWS[i]) begin
      axi(ROWS[i].wr, ROWS[i].addr, ROWS[i].data, q, r);
      chk("resp", {30'h0, r}, {30'h0, ROWS[i].resp});
      if (!ROWS[i].wr) chk("rdata", q & ROWS[i].mask, ROWS[i].data);
    end
    axi(1'b1, CT, 32'h0, q, r);
    gap(1'b0, g);
    chk("gap_std", g, 24);
    gap(1'b1, g);
    chk("gap_skip", g, 48);
    axi(1'b1, CT, 32'h2, q, r);
    gap(1'b0, g);
    gap(1'b0, g);
    chk("gap_fast", g, 12);
    axi(1'b1, CT, 32'h1, q, r);
    gap(1'b0, g);
    chk("gap_off", g, 400);
    axi(1'b1, CT, 32'h0, q, r);
    external_fetch_select_n <= 1'b0;
    repeat (8) @(posedge aclk);
    chk("fetch_ext", {31'h0, fetch_external}, 32'h1);
    axi(1'b1, CT, 32'h4, q, r);
    repeat (8) @(posedge aclk);
    chk("fetch_lock", {31'h0, fetch_external}, 32'h0);
    axi(1'b1, CT, 32'h0, q, r);
    external_fetch_select_n <= 1'b1;
    repeat (8) @(posedge aclk);
    chk("fetch_int", {31'h0, fetch_external}, 32'h0);
    axi(1'b1, MRF_PORT_OFF, 32'hB, q, r);
    ext_pull_low <= 4'h8;
    repeat (4) @(posedge aclk);
    chk("oe_n", {28'h0, port_four_oe_n}, 32'hB);
    chk("irq_a", {30'h0, ext_irq_two_n, ext_irq_three_n}, 32'h0);
    axi(1'b0, MRF_PORT_OFF, 32'h0, q, r);
    chk("port_rd", q & 32'hFF, 32'h3B);
    ext_pull_low <= 4'h4;
    axi(1'b1, MRF_PORT_OFF, 32'hF, q, r);
    repeat (4) @(posedge aclk);
    chk("irq_b", {30'h0, ext_irq_two_n, ext_irq_three_n}, 32'h2);
    ext_pull_low <= 4'h0;
    far_u.hold_reset(1, 1'b0);
    chk("rst_short", {31'h0, core_reset}, 32'h0);
    far_u.release_reset();
    repeat (8) @(posedge aclk);
    far_u.hold_reset(2, 1'b0);
    repeat (4) @(posedge aclk);
    chk("rst_long", {30'h0, core_reset, host_program_mode}, 32'h2);
    far_u.release_reset();
    repeat (8) @(posedge aclk);
    chk("rst_out", {31'h0, core_reset}, 32'h0);
    far_u.hold_reset(22, 1'b1);
    chk("host", {31'h0, host_program_mode}, 32'h1);
    far_u.release_reset();
    stop_test();
  end
endmodule
`default_nettype wire
